// file: inc/tcc_pkg.sv
// Shared constants and types for the timer/counter with clock select and capture
package tcc_pkg;
   localparam int AW = 3;
   localparam int DW = 8;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic          wr;
      logic          rd;
   } tcc_bus_t;

   // Register offsets
   localparam logic [AW-1:0] OFS_CTRL_A  = 3'h0;
   localparam logic [AW-1:0] OFS_CTRL_B  = 3'h1;
   localparam logic [AW-1:0] OFS_CNT_LO  = 3'h2;
   localparam logic [AW-1:0] OFS_CNT_HI  = 3'h3;
   localparam logic [AW-1:0] OFS_CMP_A   = 3'h4;
   localparam logic [AW-1:0] OFS_CMP_B   = 3'h5;
   localparam logic [AW-1:0] OFS_FLAGS   = 3'h6;
   localparam logic [AW-1:0] OFS_IRQ_EN  = 3'h7;

   // timer_control_a fields
   localparam int A_CTC     = 0;
   localparam int A_WIDE    = 1;
   localparam int A_CAPEN   = 2;
   localparam int A_ACSEL   = 3;
   localparam int A_CAPRISE = 4;
   localparam int A_USED    = 5;
   // timer_control_b fields
   localparam int B_CS_LSB  = 0;
   localparam int B_CS_W    = 3;
   localparam int B_PSR     = 7;
   // Flag and enable bit positions
   localparam int F_OVF     = 0;
   localparam int F_CAP     = 1;
   localparam int F_CMPA    = 2;
   localparam int F_CMPB    = 3;
   localparam int F_W       = 4;

   localparam logic [DW-1:0] RST_BYTE = 8'h00;
   localparam logic [DW-1:0] BOTTOM   = 8'h00;
   localparam logic [DW-1:0] MAX8     = 8'hFF;
   localparam logic [15:0]   MAX16    = 16'hFFFF;

   // Clock source select encodings
   localparam logic [2:0] CS_STOP     = 3'h0;
   localparam logic [2:0] CS_DIV1     = 3'h1;
   localparam logic [2:0] CS_DIV8     = 3'h2;
   localparam logic [2:0] CS_DIV64    = 3'h3;
   localparam logic [2:0] CS_DIV256   = 3'h4;
   localparam logic [2:0] CS_DIV1024  = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   // Prescaler tap widths: divide by 2**n
   localparam int PS_W      = 10;
   localparam int TAP8      = 3;
   localparam int TAP64     = 6;
   localparam int TAP256    = 8;
   localparam int TAP1024   = 10;

   // Synchronised input indices
   localparam int IN_EXT    = 0;
   localparam int IN_CAP    = 1;
   localparam int IN_ACO    = 2;
   localparam int IN_N      = 3;
endpackage

// file: rtl/tcc_timer.sv
// Timer/counter: clock select, prescaler, external count input, counter and capture
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module tcc_timer
   import tcc_pkg::*;
(
   input  wire logic             i_clk_sys,           // System clock, 125 MHz
   input  wire logic             i_nrst,              // Async reset, active low
   input  wire tcc_pkg::tcc_bus_t i_bus,              // Register access request
   output logic [tcc_pkg::DW-1:0] o_rdata,            // Read data, cycle after read
   input  wire logic             i_ext_count_pin,     // External count clock pin
   input  wire logic             i_capture_input_pin, // Capture event pin
   input  wire logic             i_comparator_output, // Analog comparator result
   input  wire logic             i_ovf_ack,           // Overflow interrupt serviced
   input  wire logic             i_cap_ack,           // Capture interrupt serviced
   input  wire logic             i_cmpa_ack,          // Compare A interrupt serviced
   input  wire logic             i_cmpb_ack,          // Compare B interrupt serviced
   output logic                  o_irq_ovf,           // Overflow interrupt request
   output logic                  o_irq_cap,           // Capture interrupt request
   output logic                  o_irq_cmpa,          // Compare A interrupt request
   output logic                  o_irq_cmpb           // Compare B interrupt request
);
   import tcc_pkg::*;

   //////////////////////////////////////////////////////////////////////////
   // Storage
   logic [A_USED-1:0] ctrl_a_reg;
   logic [B_CS_W-1:0] cs_reg;
   logic [PS_W-1:0]   ps_reg;
   logic [15:0]       cnt_reg;
   logic [DW-1:0]     cmp_a_reg;
   logic [DW-1:0]     cmp_b_reg;
   logic [F_W-1:0]    flag_reg;
   logic [F_W-1:0]    flag_next;
   logic [F_W-1:0]    irq_en_reg;
   logic [DW-1:0]     rdata_reg;
   logic              block_reg;
   logic              cap_prev_reg;
   logic [F_W-1:0]    irq_reg;
   logic [IN_N-1:0]   half_reg;
   logic [IN_N-1:0]   sync_reg;
   logic [IN_N-1:0]   prev_reg;
   logic [IN_N-1:0]   pins;

   logic              wr_ctrl_a;
   logic              wr_ctrl_b;
   logic              wr_cnt_lo;
   logic              wr_cnt_hi;
   logic              wr_cmp_a;
   logic              wr_cmp_b;
   logic              wr_flags;
   logic              wr_irq_en;
   logic              tick;
   logic              ext_rise_reg;
   logic              ext_fall_reg;
   logic              wide;
   logic              capen;
   logic              ctc;
   logic              cnt_wr;
   logic              wrap;
   logic              match_a;
   logic              match_b;
   logic              cap_src;
   logic              cap_trig;
   logic [F_W-1:0]    set_ev;
   logic [F_W-1:0]    clr_ev;
   logic [DW-1:0]     rd_mux;

   function automatic logic wr_hit(input tcc_bus_t b, input logic [AW-1:0] ofs);
      wr_hit = b.wr && (b.addr == ofs);
   endfunction

   // Tap fires once per 2**n clocks, when the low n bits are all ones
   function automatic logic tap(input logic [PS_W-1:0] p, input int n);
      logic [PS_W-1:0] mask;
      mask = PS_W'((1 << n) - 1);
      tap  = ((p & mask) == mask);
   endfunction

   assign wr_ctrl_a = wr_hit(i_bus, OFS_CTRL_A);
   assign wr_ctrl_b = wr_hit(i_bus, OFS_CTRL_B);
   assign wr_cnt_lo = wr_hit(i_bus, OFS_CNT_LO);
   assign wr_cnt_hi = wr_hit(i_bus, OFS_CNT_HI);
   assign wr_cmp_a  = wr_hit(i_bus, OFS_CMP_A);
   assign wr_cmp_b  = wr_hit(i_bus, OFS_CMP_B);
   assign wr_flags  = wr_hit(i_bus, OFS_FLAGS);
   assign wr_irq_en = wr_hit(i_bus, OFS_IRQ_EN);

   //////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_a_reg <= RST_BYTE[A_USED-1:0];
      end else if (wr_ctrl_a) begin
         ctrl_a_reg <= i_bus.wdata[A_USED-1:0];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         cs_reg <= RST_BYTE[B_CS_W-1:0];
      end else if (wr_ctrl_b) begin
         cs_reg <= i_bus.wdata[B_CS_LSB +: B_CS_W];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_en_reg <= RST_BYTE[F_W-1:0];
      end else if (wr_irq_en) begin
         irq_en_reg <= i_bus.wdata[F_W-1:0];
      end
   end

   assign wide  = ctrl_a_reg[A_WIDE];
   assign capen = ctrl_a_reg[A_CAPEN];
   // Clear-on-match exists only in plain 8-bit mode
   assign ctc   = ctrl_a_reg[A_CTC] && !wide && !capen;

   //////////////////////////////////////////////////////////////////////////
   // Prescaler: never gated by the clock select, so taps keep their phase
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         ps_reg <= '0;
      end else if (wr_ctrl_b && i_bus.wdata[B_PSR]) begin
         ps_reg <= '0;
      end else begin
         ps_reg <= ps_reg + PS_W'(1);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: the falling-edge stage stands in for a latch open
   // while the clock is high; the second stage alone reads it
   assign pins = {i_comparator_output, i_capture_input_pin, i_ext_count_pin};

   genvar gi;
   generate
      for (gi = 0; gi < IN_N; gi++) begin : g_sync
         always_ff @(negedge i_clk_sys or negedge i_nrst) begin
            if (!i_nrst) begin
               half_reg[gi] <= 1'b0;
            end else begin
               half_reg[gi] <= pins[gi];
            end
         end
         always_ff @(posedge i_clk_sys or negedge i_nrst) begin
            if (!i_nrst) begin
               sync_reg[gi] <= 1'b0;
               prev_reg[gi] <= 1'b0;
            end else begin
               sync_reg[gi] <= half_reg[gi];
               prev_reg[gi] <= sync_reg[gi];
            end
         end
      end
   endgenerate

   // Registered edge pulse: without this stage a pin edge would reach the
   // counter after only 1.5 to 2.5 clocks instead of 2.5 to 3.5
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         ext_rise_reg <= 1'b0;
         ext_fall_reg <= 1'b0;
      end else begin
         ext_rise_reg <= sync_reg[IN_EXT] && !prev_reg[IN_EXT];
         ext_fall_reg <= !sync_reg[IN_EXT] && prev_reg[IN_EXT];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Clock select
   always_comb begin
      case (cs_reg)
         CS_STOP:     tick = 1'b0;
         CS_DIV1:     tick = 1'b1;
         CS_DIV8:     tick = tap(ps_reg, TAP8);
         CS_DIV64:    tick = tap(ps_reg, TAP64);
         CS_DIV256:   tick = tap(ps_reg, TAP256);
         CS_DIV1024:  tick = tap(ps_reg, TAP1024);
         CS_EXT_FALL: tick = ext_fall_reg;
         CS_EXT_RISE: tick = ext_rise_reg;
         default:     tick = 1'b0;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // Counter unit
   assign cnt_wr  = wr_cnt_lo || wr_cnt_hi;
   assign wrap    = tick && !cnt_wr &&
                    (wide ? (cnt_reg == MAX16) : (cnt_reg[7:0] == MAX8));
   // A write to the counter masks compare matches on the next tick
   assign match_a = tick && !block_reg && !capen &&
                    (wide ? (cnt_reg == {cmp_b_reg, cmp_a_reg})
                          : (cnt_reg[7:0] == cmp_a_reg));
   assign match_b = tick && !block_reg && !wide &&
                    (cnt_reg[7:0] == cmp_b_reg);

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_reg <= 16'h0000;
      end else if (wr_cnt_lo) begin
         cnt_reg[7:0] <= i_bus.wdata;
      end else if (wr_cnt_hi) begin
         cnt_reg[15:8] <= i_bus.wdata;
      end else if (tick) begin
         if (wide) begin
            cnt_reg <= cnt_reg + 16'h0001;
         end else if (ctc && (cnt_reg[7:0] == cmp_a_reg)) begin
            cnt_reg[7:0] <= BOTTOM;
         end else begin
            cnt_reg[7:0] <= cnt_reg[7:0] + 8'h01;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         block_reg <= 1'b0;
      end else if (cnt_wr) begin
         block_reg <= 1'b1;
      end else if (tick) begin
         block_reg <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Capture unit: the edge is taken after the source mux, so switching
   // source can itself look like an edge
   assign cap_src  = ctrl_a_reg[A_ACSEL] ? sync_reg[IN_ACO] : sync_reg[IN_CAP];
   assign cap_trig = capen && (cap_src != cap_prev_reg) &&
                     (cap_src == ctrl_a_reg[A_CAPRISE]);

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         cap_prev_reg <= 1'b0;
      end else begin
         cap_prev_reg <= cap_src;
      end
   end

   // A capture overrides a simultaneous software write of the same byte
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         cmp_a_reg <= RST_BYTE;
      end else if (cap_trig) begin
         cmp_a_reg <= cnt_reg[7:0];
      end else if (wr_cmp_a) begin
         cmp_a_reg <= i_bus.wdata;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         cmp_b_reg <= RST_BYTE;
      end else if (cap_trig && wide) begin
         cmp_b_reg <= cnt_reg[15:8];
      end else if (wr_cmp_b) begin
         cmp_b_reg <= i_bus.wdata;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Flags: a new event beats a clear landing in the same cycle
   always_comb begin
      set_ev         = '0;
      set_ev[F_OVF]  = wrap;
      set_ev[F_CAP]  = cap_trig;
      set_ev[F_CMPA] = match_a;
      set_ev[F_CMPB] = match_b;
      clr_ev         = wr_flags ? i_bus.wdata[F_W-1:0] : '0;
      clr_ev[F_OVF]  = clr_ev[F_OVF] | i_ovf_ack;
      clr_ev[F_CAP]  = clr_ev[F_CAP] | i_cap_ack;
      clr_ev[F_CMPA] = clr_ev[F_CMPA] | i_cmpa_ack;
      clr_ev[F_CMPB] = clr_ev[F_CMPB] | i_cmpb_ack;
      flag_next      = (flag_reg & ~clr_ev) | set_ev;
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         flag_reg <= '0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_reg <= '0;
      end else begin
         irq_reg <= flag_reg & irq_en_reg;
      end
   end

   assign o_irq_ovf  = irq_reg[F_OVF];
   assign o_irq_cap  = irq_reg[F_CAP];
   assign o_irq_cmpa = irq_reg[F_CMPA];
   assign o_irq_cmpb = irq_reg[F_CMPB];

   //////////////////////////////////////////////////////////////////////////
   // Read port: data valid only in the cycle after the strobe
   always_comb begin
      rd_mux = RST_BYTE;
      case (i_bus.addr)
         OFS_CTRL_A: rd_mux[A_USED-1:0] = ctrl_a_reg;
         OFS_CTRL_B: rd_mux[B_CS_LSB +: B_CS_W] = cs_reg;
         OFS_CNT_LO: rd_mux = cnt_reg[7:0];
         OFS_CNT_HI: rd_mux = cnt_reg[15:8];
         OFS_CMP_A:  rd_mux = cmp_a_reg;
         OFS_CMP_B:  rd_mux = cmp_b_reg;
         OFS_FLAGS:  rd_mux[F_W-1:0] = flag_reg;
         OFS_IRQ_EN: rd_mux[F_W-1:0] = irq_en_reg;
         default:    rd_mux = RST_BYTE;
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         rdata_reg <= RST_BYTE;
      end else if (i_bus.rd) begin
         rdata_reg <= rd_mux;
      end else begin
         rdata_reg <= RST_BYTE;
      end
   end

   assign o_rdata = rdata_reg;
endmodule

// file: bench/tcc_timer_assertions.sv
// Port-level assertion checker for the timer/counter, bound to its top module
`timescale 1ns/1ps
module tcc_timer_chk
   import tcc_pkg::*;
(
   input  wire logic              i_clk_sys,           // System clock
   input  wire logic              i_nrst,              // Async reset, active low
   input  wire tcc_pkg::tcc_bus_t i_bus,               // Register request
   input  wire logic [tcc_pkg::DW-1:0] o_rdata,        // Read data
   input  wire logic              i_capture_input_pin, // Capture pin
   input  wire logic              i_comparator_output, // Comparator output
   input  wire logic              i_cap_ack,           // Capture serviced
   input  wire logic              o_irq_ovf,           // Overflow request
   input  wire logic              o_irq_cap,           // Capture request
   input  wire logic              o_irq_cmpa,          // Compare A request
   input  wire logic              o_irq_cmpb           // Compare B request
);
   import tcc_pkg::*;
   //////////////////////////////////////////////////////////////////////////////
   // Shadows of software-written control bits, rebuilt from bus writes
   logic [3:0] en_sh;
   logic [2:0] cs_sh;
   logic       ctc_sh;
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         en_sh  <= 4'h0;
         cs_sh  <= CS_STOP;
         ctc_sh <= 1'b0;
      end else if (i_bus.wr) begin
         if (i_bus.addr == OFS_IRQ_EN) en_sh <= i_bus.wdata[3:0];
         if (i_bus.addr == OFS_CTRL_B) cs_sh <= i_bus.wdata[2:0];
         if (i_bus.addr == OFS_CTRL_A) ctc_sh <= i_bus.wdata[A_CTC];
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);

   a_rdata_idle: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
      else $error("read data not zero outside the read slot");
   a_psr_reads_zero: assert property ($past(i_bus.rd && i_bus.addr == OFS_CTRL_B) |-> !o_rdata[B_PSR])
      else $error("prescaler reset bit reads back as one");
   // Stopped source: two back-to-back reads of the low byte agree
   a_stop_hold: assert property ((i_bus.rd && i_bus.addr == OFS_CNT_LO && cs_sh == CS_STOP)
      ##1 (i_bus.rd && i_bus.addr == OFS_CNT_LO) |-> ##1 o_rdata == $past(o_rdata))
      else $error("counter moved with no clock source");
   // Undivided source: back-to-back reads step by exactly one
   a_div1_step: assert property ((i_bus.rd && i_bus.addr == OFS_CNT_LO && cs_sh == CS_DIV1
      && $past(cs_sh) == CS_DIV1 && !ctc_sh) ##1 (i_bus.rd && i_bus.addr == OFS_CNT_LO)
      |-> ##1 o_rdata == $past(o_rdata) + 8'h01)
      else $error("counter did not advance once per clock");
   a_irq_ovf_en: assert property (o_irq_ovf |-> $past(en_sh[F_OVF]))
      else $error("overflow request while disabled");
   a_irq_cap_en: assert property (o_irq_cap |-> $past(en_sh[F_CAP]))
      else $error("capture request while disabled");
   a_irq_mask_off: assert property ((i_bus.wr && i_bus.addr == OFS_IRQ_EN && i_bus.wdata[3:0] == 4'h0)
      ##1 !(i_bus.wr && i_bus.addr == OFS_IRQ_EN) |-> ##1 !(o_irq_ovf || o_irq_cap || o_irq_cmpa || o_irq_cmpb))
      else $error("request stayed up after all enables cleared");
   // Quiet capture sources, so nothing can set the flag again behind the ack
   a_cap_ack_clr: assert property (($stable(i_capture_input_pin) && $stable(i_comparator_output)
      && !i_bus.wr) [*4] ##0 i_cap_ack |-> ##2 !o_irq_cap)
      else $error("capture request not withdrawn after service");
endmodule

bind tcc_timer tcc_timer_chk tcc_timer_chk_inst (
   .i_clk_sys           (i_clk_sys),
   .i_nrst              (i_nrst),
   .i_bus               (i_bus),
   .o_rdata             (o_rdata),
   .i_capture_input_pin (i_capture_input_pin),
   .i_comparator_output (i_comparator_output),
   .i_cap_ack           (i_cap_ack),
   .o_irq_ovf           (o_irq_ovf),
   .o_irq_cap           (o_irq_cap),
   .o_irq_cmpa          (o_irq_cmpa),
   .o_irq_cmpb          (o_irq_cmpb)
);

// file: bench/tcc_src_model.sv
// Far-side sources: external count clock, capture pin and comparator output
`timescale 1ns/1ps
module tcc_src_model (
   output logic o_ext_count_pin,     // Count clock to the timer
   output logic o_capture_input_pin, // Capture event line
   output logic o_comparator_output  // Comparator result
);
   initial begin
      o_ext_count_pin     = 1'b0; // Rests low between bursts
      o_capture_input_pin = 1'b0;
      o_comparator_output = 1'b0;
   end
   // Offset of 3 ns keeps every change clear of both clock edges
   task automatic ext_pulses(input int n);
      #3;
      for (int k = 0; k < n; k++) begin
         #20 o_ext_count_pin = 1'b1; // Half period 20 ns, above one clock
         #20 o_ext_count_pin = 1'b0;
      end
   endtask
   task automatic set_cap(input logic v);
      #3 o_capture_input_pin = v;
   endtask
   task automatic set_cmp(input logic v);
      #3 o_comparator_output = v;
   endtask
endmodule

// file: bench/tcc_timer_tb.sv
// Self-checking testbench for the timer/counter
`timescale 1ns/1ps
module tcc_timer_tb;
   import tcc_pkg::*;
   typedef struct packed {
      logic [2:0] cs;
      int         win;
      int         np;
      logic [7:0] exp;
   } tcc_row_t;
   // Window in clocks from start to stop; pulses on the count pin meanwhile
   localparam tcc_row_t ROWS [8] = '{
      '{CS_STOP, 40, 2, 8'h00}, '{CS_DIV1, 37, 3, 8'h25}, '{CS_DIV8, 44, 2, 8'h05},
      '{CS_DIV64, 224, 0, 8'h03}, '{CS_DIV256, 640, 0, 8'h02}, '{CS_DIV1024, 2560, 0, 8'h02},
      '{CS_EXT_FALL, 60, 5, 8'h05}, '{CS_EXT_RISE, 60, 7, 8'h07}};
   logic       i_clk_sys;
   logic       i_nrst;
   tcc_bus_t   bus;
   logic [7:0] o_rdata;
   logic       ext_pin;
   logic       cap_pin;
   logic       cmp_out;
   logic       ovf_ack;
   logic       cap_ack;
   logic       irq_ovf;
   logic       irq_cap;
   logic [7:0] rd;
   logic [7:0] v2;
   int         n_mismatch;
   int         compares;

   tcc_src_model tcc_src_model_inst (
      .o_ext_count_pin     (ext_pin),
      .o_capture_input_pin (cap_pin),
      .o_comparator_output (cmp_out)
   );
   tcc_timer tcc_timer_inst (
      .i_clk_sys           (i_clk_sys),
      .i_nrst              (i_nrst),
      .i_bus               (bus),
      .o_rdata             (o_rdata),
      .i_ext_count_pin     (ext_pin),
      .i_capture_input_pin (cap_pin),
      .i_comparator_output (cmp_out),
      .i_ovf_ack           (ovf_ack),
      .i_cap_ack           (cap_ack),
      .i_cmpa_ack          (1'b0),
      .i_cmpb_ack          (1'b0),
      .o_irq_ovf           (irq_ovf),
      .o_irq_cap           (irq_cap),
      .o_irq_cmpa          (),
      .o_irq_cmpb          ()
   );
   //////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk_sys);
      bus <= '0;
   endtask
   task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk_sys);
      bus <= '0;
      #1;
      d = o_rdata;
   endtask
   // Counter write, then two reads back to back with no gap
   task automatic wr_rd2(input logic [7:0] d, output logic [7:0] r1, output logic [7:0] r2);
      @(posedge i_clk_sys);
      bus <= '{addr: OFS_CNT_LO, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk_sys);
      bus <= '{addr: OFS_CNT_LO, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk_sys);
      #1;
      r1 = o_rdata;
      @(posedge i_clk_sys);
      bus <= '0;
      #1;
      r2 = o_rdata;
   endtask
   task automatic ack_pulse(input bit cap);
      @(posedge i_clk_sys);
      if (cap) cap_ack <= 1'b1; else ovf_ack <= 1'b1;
      @(posedge i_clk_sys);
      cap_ack <= 1'b0;
      ovf_ack <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      #1;
   endtask
   // Prescaler restarted with the start write, so the window alone sets the count
   task automatic run_win(input logic [2:0] cs, input int win, input int np);
      bus_wr(OFS_CNT_LO, 8'h00);
      bus_wr(OFS_CTRL_B, {5'h10, cs});
      fork
         tcc_src_model_inst.ext_pulses(np);
         repeat (win - 2) @(posedge i_clk_sys);
      join
      bus_wr(OFS_CTRL_B, 8'h00);
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      #200000;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      i_nrst = 1'b0;
      bus = '0;
      ovf_ack = 1'b0;
      cap_ack = 1'b0;
      n_mismatch = 0;
      compares = 0;
      repeat (8) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      for (int a = 0; a < 8; a++) begin
         bus_rd(3'(a), rd);
         check("reset value", rd, 8'h00);
      end
      wr_rd2(8'hA5, rd, v2);
      check("stopped count", v2, 8'hA5);
      foreach (ROWS[i]) begin
         run_win(ROWS[i].cs, ROWS[i].win, ROWS[i].np);
         bus_rd(OFS_CNT_LO, rd);
         check("count", rd, ROWS[i].exp);
      end
      bus_wr(OFS_CTRL_A, 8'h01);
      bus_wr(OFS_CMP_A, 8'h05);
      run_win(CS_DIV1, 37, 0);
      bus_rd(OFS_CNT_LO, rd);
      check("clear on match", rd, 8'h01);
      bus_wr(OFS_CTRL_A, 8'h00);
      bus_wr(OFS_CTRL_B, {5'h00, CS_DIV1});
      wr_rd2(8'h10, rd, v2);
      check("write wins", rd, 8'h10);
      check("next tick", v2, 8'h11);
      bus_wr(OFS_IRQ_EN, 8'h01);
      bus_wr(OFS_CNT_LO, 8'hF0);
      repeat (20) @(posedge i_clk_sys);
      #1;
      check("ovf irq", {7'h00, irq_ovf}, 8'h01);
      bus_rd(OFS_FLAGS, rd);
      check("ovf flag", {7'h00, rd[F_OVF]}, 8'h01);
      check("cmp b flag", {7'h00, rd[F_CMPB]}, 8'h01);
      ack_pulse(1'b0);
      check("ovf irq acked", {7'h00, irq_ovf}, 8'h00);
      bus_wr(OFS_CTRL_B, 8'h00);
      bus_wr(OFS_IRQ_EN, 8'h00);
      bus_wr(OFS_IRQ_EN, 8'h02);
      bus_wr(OFS_CTRL_A, 8'h14);
      bus_wr(OFS_CMP_B, 8'h77);
      bus_wr(OFS_CNT_LO, 8'h5A);
      tcc_src_model_inst.set_cap(1'b1);
      repeat (6) @(posedge i_clk_sys);
      bus_rd(OFS_CMP_A, rd);
      check("capture low", rd, 8'h5A);
      bus_rd(OFS_CMP_B, rd);
      check("cmp b kept", rd, 8'h77);
      bus_rd(OFS_FLAGS, rd);
      check("cap flag", {7'h00, rd[F_CAP]}, 8'h01);
      check("cap irq", {7'h00, irq_cap}, 8'h01);
      bus_wr(OFS_CNT_LO, 8'h33);
      tcc_src_model_inst.set_cap(1'b0);
      repeat (6) @(posedge i_clk_sys);
      bus_rd(OFS_CMP_A, rd);
      check("wrong edge", rd, 8'h5A);
      bus_wr(OFS_FLAGS, 8'h02);
      bus_rd(OFS_FLAGS, rd);
      check("flag w1c", {7'h00, rd[F_CAP]}, 8'h00);
      bus_wr(OFS_CTRL_A, 8'h1E);
      bus_wr(OFS_CNT_HI, 8'hC3);
      tcc_src_model_inst.set_cmp(1'b1);
      repeat (6) @(posedge i_clk_sys);
      bus_rd(OFS_CMP_A, rd);
      check("wide low", rd, 8'h33);
      bus_rd(OFS_CMP_B, rd);
      check("wide high", rd, 8'hC3);
      check("cap irq wide", {7'h00, irq_cap}, 8'h01);
      ack_pulse(1'b1);
      check("cap irq acked", {7'h00, irq_cap}, 8'h00);
      bus_rd(OFS_FLAGS, rd);
      check("flag serviced", {7'h00, rd[F_CAP]}, 8'h00);
      end_of_test();
   end
endmodule
